// ### spi_master_slave_port.sv
// byte-wide master/slave serial port with avalon-mm register access
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_port (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        sub_clock_i,
   input  wire logic        timer_match_i,
   input  wire logic        serial_in_line_i,
   output logic             serial_out_line_o,
   output logic             serial_out_line_oe_o,
   input  wire logic        shift_clock_line_i,
   output logic             shift_clock_line_o,
   output logic             shift_clock_line_oe_o,
   input  wire logic        slave_select_line_n_i,
   output logic             transfer_irq_o
);
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LEAD  = 2'b01,
      ST_TRAIL = 2'b10
   } state_type;

   // three-stage synchronisers for pins and asynchronous clock sources
   logic [2:0] sck_sync_q, sck_sync_d;
   logic [2:0] ssn_sync_q, ssn_sync_d;
   logic [2:0] sub_sync_q, sub_sync_d;
   logic [2:0] sdi_sync_q, sdi_sync_d;
   logic       sck_val_q, sck_val_d;
   logic       ssn_val_q, ssn_val_d;
   logic       sub_val_q, sub_val_d;

   logic [7:0] mode_ctl_q, mode_ctl_d;
   logic [7:0] fmt_q, fmt_d;
   logic [7:0] data_q, data_d;
   logic [7:0] shift_q, shift_d;
   logic [3:0] bit_cnt_q, bit_cnt_d;
   logic [5:0] div_q, div_d;
   logic [2:0] cap_pipe_q, cap_pipe_d;
   logic [7:0] rx_q, rx_d;
   logic       sclk_q, sclk_d;
   logic       sdo_q, sdo_d;
   logic       busy_q, busy_d;
   state_type  state_q, state_d;
   logic       ack_q, ack_d;
   logic [7:0] rdata_q, rdata_d;

   spi_port_pkg::mode_type mode;
   logic en, sel_en, pol, edge_sel, msb_first, is_master, is_slave;
   logic selected, tick, lead_in, trail_in, sck_rise, sck_fall;
   logic bus_req, wr_mode, wr_fmt, wr_data;

   // sampling edge seen on the line: rise when pol xor edge is 0
   function automatic logic is_capture(input logic p, input logic e,
                                       input logic rise);
      is_capture = rise ? ~(p ^ e) : (p ^ e);
   endfunction : is_capture

   function automatic logic [7:0] shift_in(input logic [7:0] s,
                                           input logic msb,
                                           input logic b);
      shift_in = msb ? {s[6:0], b} : {b, s[7:1]};
   endfunction : shift_in

   function automatic logic out_bit(input logic [7:0] s, input logic msb);
      out_bit = msb ? s[7] : s[0];
   endfunction : out_bit

   assign mode      = spi_port_pkg::mode_type'(mode_ctl_q[7:5]);
   assign en        = mode_ctl_q[spi_port_pkg::PORT_EN_POS];
   assign pol       = fmt_q[spi_port_pkg::POLARITY_POS];
   assign edge_sel  = fmt_q[spi_port_pkg::EDGE_POS];
   assign msb_first = fmt_q[spi_port_pkg::ORDER_POS];
   assign sel_en    = fmt_q[spi_port_pkg::SEL_EN_POS];
   assign is_slave  = (mode == spi_port_pkg::MODE_SLAVE);
   assign is_master = (mode[2] == 1'b0) || (mode == spi_port_pkg::MODE_TIMER);
   assign selected  = ~sel_en | ~ssn_val_q;

   assign bus_req = (avs_read_i | avs_write_i) & ~ack_q;
   // a write lands only at the edge where waitrequest is already low
   assign wr_mode = avs_write_i & ack_q &
                    (avs_address_i == spi_port_pkg::MODE_CONTROL_OFS);
   assign wr_fmt  = avs_write_i & ack_q &
                    (avs_address_i == spi_port_pkg::FORMAT_STATUS_OFS);
   assign wr_data = avs_write_i & ack_q &
                    (avs_address_i == spi_port_pkg::SHIFT_DATA_OFS);

   // synchronisers; a value changes only when stages two and three agree
   always_comb begin
      sck_sync_d = {sck_sync_q[1:0], shift_clock_line_i};
      ssn_sync_d = {ssn_sync_q[1:0], slave_select_line_n_i};
      sub_sync_d = {sub_sync_q[1:0], sub_clock_i};
      sdi_sync_d = {sdi_sync_q[1:0], serial_in_line_i};
      sck_val_d  = (sck_sync_q[2] == sck_sync_q[1]) ? sck_sync_q[2] : sck_val_q;
      ssn_val_d  = (ssn_sync_q[2] == ssn_sync_q[1]) ? ssn_sync_q[2] : ssn_val_q;
      sub_val_d  = (sub_sync_q[2] == sub_sync_q[1]) ? sub_sync_q[2] : sub_val_q;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sck_sync_q <= 3'h7;
         ssn_sync_q <= 3'h7;
         sub_sync_q <= 3'h0;
         sdi_sync_q <= 3'h0;
         sck_val_q  <= 1'b1;
         ssn_val_q  <= 1'b1;
         sub_val_q  <= 1'b0;
      end else begin
         sck_sync_q <= sck_sync_d;
         ssn_sync_q <= ssn_sync_d;
         sub_sync_q <= sub_sync_d;
         sdi_sync_q <= sdi_sync_d;
         sck_val_q  <= sck_val_d;
         ssn_val_q  <= ssn_val_d;
         sub_val_q  <= sub_val_d;
      end
   end

   assign sck_rise = sck_val_d & ~sck_val_q;
   assign sck_fall = ~sck_val_d & sck_val_q;

   // master half-period tick; sub clock gives one tick per edge, timer one per clock with match high
   always_comb begin
      div_d      = div_q;
      tick       = 1'b0;
      if (!busy_q || !is_master) begin
         div_d = 6'h00;
      end else begin
         case (mode)
            spi_port_pkg::MODE_DIV4,
            spi_port_pkg::MODE_DIV16,
            spi_port_pkg::MODE_DIV64: begin
               div_d = div_q + 6'h01;
               if ((mode == spi_port_pkg::MODE_DIV4 &&
                    div_d == spi_port_pkg::HALF_DIV4) ||
                   (mode == spi_port_pkg::MODE_DIV16 &&
                    div_d == spi_port_pkg::HALF_DIV16) ||
                   (mode == spi_port_pkg::MODE_DIV64 &&
                    div_d == spi_port_pkg::HALF_DIV64)) begin
                  tick  = 1'b1;
                  div_d = 6'h00;
               end
            end
            spi_port_pkg::MODE_SUB: tick = sub_val_d ^ sub_val_q;
            spi_port_pkg::MODE_TIMER: begin
               // each match toggles the line: clock is match rate / 2
               tick = timer_match_i;
            end
            default: tick = 1'b0;
         endcase
      end
   end

   // leading and trailing edges of a bit cell
   always_comb begin
      lead_in  = 1'b0;
      trail_in = 1'b0;
      if (is_master) begin
         lead_in  = tick & (state_q == ST_LEAD);
         trail_in = tick & (state_q == ST_TRAIL);
      end else if (is_slave && selected) begin
         lead_in  = is_capture(pol, edge_sel, 1'b1) ? sck_rise : sck_fall;
         trail_in = is_capture(pol, edge_sel, 1'b1) ? sck_fall : sck_rise;
      end
   end

   // shifter, flags and registers
   always_comb begin
      mode_ctl_d = mode_ctl_q;
      fmt_d      = fmt_q;
      data_d     = data_q;
      shift_d    = shift_q;
      bit_cnt_d  = bit_cnt_q;
      sclk_d     = sclk_q;
      sdo_d      = sdo_q;
      busy_d     = busy_q;
      state_d    = state_q;
      rx_d       = rx_q;
      cap_pipe_d = {cap_pipe_q[1:0], is_master & lead_in};
      if (wr_mode) begin
         mode_ctl_d = avs_writedata_i[7:0] & 8'hE3;
      end
      if (wr_fmt) begin
         fmt_d = avs_writedata_i[7:0] & 8'h3F;
      end
      if (!busy_q) begin
         sclk_d = pol ? 1'b0 : 1'b1;
      end
      if (wr_data) begin
         if (busy_q) begin
            fmt_d[spi_port_pkg::COLLISION_POS] = 1'b1;
         end else begin
            data_d  = avs_writedata_i[7:0];
            shift_d = avs_writedata_i[7:0];
            sdo_d   = out_bit(avs_writedata_i[7:0], msb_first);
            if (en && is_master) begin
               busy_d    = 1'b1;
               bit_cnt_d = 4'h0;
               state_d   = edge_sel ? ST_LEAD : ST_TRAIL;
               fmt_d[spi_port_pkg::COMPLETE_POS] = 1'b0;
            end
         end
      end
      if (is_slave && en && selected && !busy_q && (lead_in || trail_in)) begin
         busy_d    = 1'b1;
         bit_cnt_d = 4'h0;
         fmt_d[spi_port_pkg::COMPLETE_POS] = 1'b0;
      end
      if (is_master && busy_q && tick && state_q != ST_IDLE) begin
         sclk_d = ~sclk_q;
         state_d = (state_q == ST_LEAD) ? ST_TRAIL : ST_LEAD;
      end
      // edge=1 captures on the first toggle, edge=0 launches on it
      if (busy_q || (is_slave && en && selected)) begin
         if (lead_in) begin
            shift_d   = shift_in(shift_q, msb_first, sdi_sync_q[2]);
            bit_cnt_d = bit_cnt_q + 4'h1;
            if (bit_cnt_q == spi_port_pkg::BITS_PER_BYTE - 4'h1) begin
               state_d = ST_IDLE;
               if (!is_master) begin
                  data_d    = shift_in(shift_q, msb_first, sdi_sync_q[2]);
                  busy_d    = 1'b0;
                  bit_cnt_d = 4'h0;
                  fmt_d[spi_port_pkg::COMPLETE_POS] = 1'b1;
               end
            end
         end
         if (trail_in && bit_cnt_q != 4'h0) begin
            sdo_d = out_bit(shift_q, msb_first);
         end
      end
      // master reads the input three clocks after its capture edge, so the
      // synchroniser delay cannot hand it the previous bit at /4
      if (is_master && busy_q && cap_pipe_q[2]) begin
         rx_d = shift_in(rx_q, msb_first, sdi_sync_q[2]);
         if (state_q == ST_IDLE && cap_pipe_q[1:0] == 2'b00) begin
            data_d    = rx_d;
            busy_d    = 1'b0;
            bit_cnt_d = 4'h0;
            fmt_d[spi_port_pkg::COMPLETE_POS] = 1'b1;
         end
      end
      if (is_slave && en && sel_en && busy_q && ssn_val_q) begin
         busy_d = 1'b0;
         bit_cnt_d = 4'h0;
         mode_ctl_d[spi_port_pkg::INCOMPLETE_POS] = 1'b1;
         fmt_d[spi_port_pkg::COMPLETE_POS] = 1'b1;
      end
      if (!en) begin
         busy_d  = 1'b0;
         bit_cnt_d = 4'h0;
         state_d = ST_IDLE;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mode_ctl_q <= spi_port_pkg::MODE_CONTROL_RST;
         fmt_q      <= spi_port_pkg::FORMAT_STATUS_RST;
         data_q     <= spi_port_pkg::SHIFT_DATA_RST;
         shift_q    <= spi_port_pkg::SHIFT_DATA_RST;
         bit_cnt_q  <= 4'h0;
         div_q      <= 6'h00;
         cap_pipe_q <= 3'h0;
         rx_q       <= 8'h00;
         sclk_q     <= 1'b1;
         sdo_q      <= 1'b1;
         busy_q     <= 1'b0;
         state_q    <= ST_IDLE;
      end else begin
         mode_ctl_q <= mode_ctl_d;
         fmt_q      <= fmt_d;
         data_q     <= data_d;
         shift_q    <= shift_d;
         bit_cnt_q  <= bit_cnt_d;
         div_q      <= div_d;
         cap_pipe_q <= cap_pipe_d;
         rx_q       <= rx_d;
         sclk_q     <= sclk_d;
         sdo_q      <= sdo_d;
         busy_q     <= busy_d;
         state_q    <= state_d;
      end
   end

   // bus answers one cycle after the request; unmapped reads give zero
   always_comb begin
      ack_d   = bus_req;
      rdata_d = 8'h00;
      case (avs_address_i)
         spi_port_pkg::MODE_CONTROL_OFS:  rdata_d = mode_ctl_q & 8'hE3;
         spi_port_pkg::FORMAT_STATUS_OFS: rdata_d = fmt_q & 8'h3F;
         spi_port_pkg::SHIFT_DATA_OFS:    rdata_d = data_q;
         default:                         rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
   assign avs_readdata_o    = {24'h000000, rdata_q};

   // pin drive; everything released while the port is off
   assign shift_clock_line_o    = sclk_q;
   assign shift_clock_line_oe_o = en & is_master;
   assign serial_out_line_o     = busy_q ? sdo_q : 1'b1;
   assign serial_out_line_oe_o  = en & (is_master | (is_slave & selected));
   assign transfer_irq_o        = fmt_q[spi_port_pkg::COMPLETE_POS];
endmodule : spi_master_slave_port
`default_nettype wire

// ### spi_master_slave_port_tb_top.sv
// testbench: registers, master transfers in each mode, slave abort
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_port_tb_top;
   localparam logic [3:0] CTL = spi_port_pkg::MODE_CONTROL_OFS;
   localparam logic [3:0] FMT = spi_port_pkg::FORMAT_STATUS_OFS;
   localparam logic [3:0] DAT = spi_port_pkg::SHIFT_DATA_OFS;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wd = 32'h0;
   logic        sub = 1'b0;
   logic        tmr = 1'b0;
   logic        sel_n = 1'b1;
   logic        sck_drv = 1'b1;
   logic        load = 1'b0;
   logic [2:0]  fm = 3'h0;
   logic [7:0]  tx = 8'h00;
   logic [7:0]  d, q;
   wire  [31:0] rdata;
   wire  [7:0]  mrx;
   wire         wt, sdi, sdo, sdo_oe, sck, sck_oe, irq;
   wire         sck_w = sck_oe ? sck : sck_drv;
   int          n_fail = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          i, k;
   spi_master_slave_port u_spi_master_slave_port (.clk_sys_i(clk),
      .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wt), .sub_clock_i(sub), .timer_match_i(tmr),
      .serial_in_line_i(sdi), .serial_out_line_o(sdo),
      .serial_out_line_oe_o(sdo_oe), .shift_clock_line_i(sck_w),
      .shift_clock_line_o(sck), .shift_clock_line_oe_o(sck_oe),
      .slave_select_line_n_i(sel_n), .transfer_irq_o(irq));
   spi_slave_model u_spi_slave_model (.clk_i(clk), .sck_i(sck_w),
      .sdo_i(sdo), .pol_i(fm[2]), .edge_i(fm[1]), .msb_i(fm[0]),
      .load_i(load), .tx_i(tx), .sdi_o(sdi), .rx_o(mrx));
   initial forever #50 clk = ~clk;
   // free-running sub clock and timer match pulses; cycle limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      sub <= cyc[2];
      tmr <= (cyc % 6 == 0);
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [7:0] v);
      int n;
      n = 0;
      @(posedge clk);
      wr <= w;
      rd <= ~w;
      adr <= a;
      wd <= {24'h0, v};
      do begin
         @(posedge clk);
         n++;
      end while (wt !== 1'b0 && n < 50);
      if (wt !== 1'b0) begin
         n_fail++;
         wrap_up();
      end
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rchk
   initial begin
      void'($urandom(53));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rchk(CTL, spi_port_pkg::MODE_CONTROL_RST);
      rchk(FMT, spi_port_pkg::FORMAT_STATUS_RST);
      rchk(DAT, spi_port_pkg::SHIFT_DATA_RST);
      rchk(4'hC, 8'h00);
      bus(1'b1, CTL, 8'hFF);
      rchk(CTL, 8'hE3);
      rchk(FMT, 8'h00);
      bus(1'b1, FMT, 8'hFF);
      rchk(FMT, 8'h3F);
      $display("test registers done");
      for (i = 0; i < 10; i++) begin
         fm <= i[2:0];
         tx <= 8'($urandom);
         d = 8'($urandom);
         bus(1'b1, FMT, {2'b00, i[2:0], 3'b100});
         bus(1'b1, CTL, {3'(i % 5), 5'b00010});
         @(posedge clk) load <= 1'b1;
         @(posedge clk) load <= 1'b0;
         bus(1'b1, DAT, d);
         bus(1'b1, DAT, ~d);
         rchk(FMT, {2'b00, i[2:0], 3'b110});
         for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
         chk({7'h00, irq}, 8'h01);
         rchk(FMT, {2'b00, i[2:0], 3'b111});
         rchk(DAT, tx);
         chk(mrx, d);
         $display("test master transfer %0d done", i);
      end
      bus(1'b1, FMT, 8'h04);
      bus(1'b1, CTL, 8'hA2);
      @(posedge clk) sel_n <= 1'b0;
      repeat (3) begin
         repeat (8) @(posedge clk);
         sck_drv <= ~sck_drv;
      end
      repeat (8) @(posedge clk);
      sel_n <= 1'b1;
      repeat (12) @(posedge clk);
      rchk(CTL, 8'hA3);
      rchk(FMT, 8'h05);
      chk({7'h00, irq}, 8'h01);
      $display("test slave abort done");
      wrap_up();
   end
endmodule : spi_master_slave_port_tb_top
bind spi_master_slave_port spi_port_monitor u_spi_port_monitor (.*);
`default_nettype wire

// ### spi_port_monitor.sv
// assertion checker for the serial port bus handshake, pins and flags
`timescale 1ns/10ps
`default_nettype none
module spi_port_monitor (
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic [3:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic        serial_out_line_o,
   input wire logic        serial_out_line_oe_o,
   input wire logic        shift_clock_line_o,
   input wire logic        shift_clock_line_oe_o,
   input wire logic        transfer_irq_o
);
   logic [7:0] ctl_q, ctl_d, fmt_q, fmt_d, idle_q, idle_d;
   logic       tk, en, mst, slv;
   assign tk  = avs_write_i && !avs_waitrequest_o;
   assign en  = ctl_q[spi_port_pkg::PORT_EN_POS];
   assign slv = ctl_q[7:5] == spi_port_pkg::MODE_SLAVE;
   assign mst = en && ctl_q[7:5] < spi_port_pkg::MODE_SLAVE;
   // shadow of the control bits as software last wrote them
   always_comb begin
      ctl_d = ctl_q;
      fmt_d = fmt_q;
      idle_d = 8'h00;
      if (tk && avs_address_i == spi_port_pkg::MODE_CONTROL_OFS)
         ctl_d = avs_writedata_i[7:0];
      if (tk && avs_address_i == spi_port_pkg::FORMAT_STATUS_OFS)
         fmt_d = avs_writedata_i[7:0];
      // a write may restart or reshape the clock, so idle time restarts
      if (transfer_irq_o && !tk)
         idle_d = (idle_q == 8'hFF) ? idle_q : idle_q + 8'h01;
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ctl_q  <= spi_port_pkg::MODE_CONTROL_RST;
         fmt_q  <= spi_port_pkg::FORMAT_STATUS_RST;
         idle_q <= 8'h00;
      end else begin
         ctl_q  <= ctl_d;
         fmt_q  <= fmt_d;
         idle_q <= idle_d;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_grant;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   a_bus_grant: assert property ($rose(avs_read_i || avs_write_i) |-> s_grant)
      else $error("waitrequest not low one cycle after request");
   a_read_upper: assert property (avs_read_i && !avs_waitrequest_o
      |-> avs_readdata_o[31:8] == 24'h0) else $error("upper read bits set");
   a_slave_no_clock: assert property (slv && $past(slv, 2)
      |-> !shift_clock_line_oe_o) else $error("slave drives clock");
   a_off_quiet: assert property (!en && $past(!en, 2)
      |-> !shift_clock_line_oe_o && !serial_out_line_oe_o)
      else $error("disabled port drives a line");
   a_master_drives: assert property (mst && $past(mst, 2)
      |-> shift_clock_line_oe_o && serial_out_line_oe_o)
      else $error("enabled master not driving lines");
   a_clock_idle: assert property (idle_q > 8'h28 && mst
      |-> shift_clock_line_o == !fmt_q[spi_port_pkg::POLARITY_POS])
      else $error("clock idle level wrong");
   a_out_idle: assert property (idle_q > 8'h28 && mst
      && fmt_q[spi_port_pkg::SEL_EN_POS] |-> serial_out_line_o)
      else $error("data out not idle high");
   a_irq_fall_cause: assert property ($fell(transfer_irq_o)
      |-> $past(tk) || $past(tk, 2)) else $error("flag cleared by itself");
   a_icf_no_complete: assert property (tk && !en && !transfer_irq_o
      && avs_address_i == spi_port_pkg::MODE_CONTROL_OFS
      && avs_writedata_i[spi_port_pkg::INCOMPLETE_POS]
      |=> !transfer_irq_o [*2]) else $error("incomplete write set complete");
endmodule : spi_port_monitor
`default_nettype wire

// ### spi_port_pkg.sv
// register map, field positions and timing constants of the serial port
package spi_port_pkg;
   localparam logic [3:0] MODE_CONTROL_OFS  = 4'h0;
   localparam logic [3:0] FORMAT_STATUS_OFS = 4'h4;
   localparam logic [3:0] SHIFT_DATA_OFS    = 4'h8;
   // mode control fields
   localparam int MODE_LSB      = 5;
   localparam int PORT_EN_POS   = 1;
   localparam int INCOMPLETE_POS = 0;
   localparam logic [7:0] MODE_CONTROL_RST = 8'hE0;
   // format / status fields
   localparam int POLARITY_POS  = 5;
   localparam int EDGE_POS      = 4;
   localparam int ORDER_POS     = 3;
   localparam int SEL_EN_POS    = 2;
   localparam int COLLISION_POS = 1;
   localparam int COMPLETE_POS  = 0;
   localparam logic [7:0] FORMAT_STATUS_RST = 8'h00;
   localparam logic [7:0] SHIFT_DATA_RST    = 8'h00;
   // half periods of the shift clock in system clocks
   localparam logic [5:0] HALF_DIV4  = 6'h02;
   localparam logic [5:0] HALF_DIV16 = 6'h08;
   localparam logic [5:0] HALF_DIV64 = 6'h20;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [2:0] {
      MODE_DIV4   = 3'b000,
      MODE_DIV16  = 3'b001,
      MODE_DIV64  = 3'b010,
      MODE_SUB    = 3'b011,
      MODE_TIMER  = 3'b100,
      MODE_SLAVE  = 3'b101,
      MODE_RSVD6  = 3'b110,
      MODE_RSVD7  = 3'b111
   } mode_type;
endpackage : spi_port_pkg

// ### spi_slave_model.sv
// behavioural far-side device: one byte in and one byte out per frame
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
   input  wire logic       clk_i,
   input  wire logic       sck_i,
   input  wire logic       sdo_i,
   input  wire logic       pol_i,
   input  wire logic       edge_i,
   input  wire logic       msb_i,
   input  wire logic       load_i,
   input  wire logic [7:0] tx_i,
   output logic            sdi_o,
   output logic      [7:0] rx_o
);
   logic       s_q = 1'b1;
   logic       t_q = 1'b0;
   logic [3:0] n = 4'h8;
   logic [2:0] b = 3'h0;
   logic [7:0] tx_q = 8'h00;
   wire        cap = (sck_i != s_q) && (sck_i == (pol_i == edge_i));
   // outside a frame the line is not held, so it shows a moving pattern
   assign sdi_o = (n < 4'h8) ? tx_q[msb_i ? 3'h7 - b : b] : t_q;
   always @(posedge clk_i) begin
      s_q <= sck_i;
      t_q <= ~t_q;
      if (load_i) begin
         n <= 4'h0;
         b <= 3'h0;
         tx_q <= tx_i;
      end else if (cap && n < 4'h8) begin
         rx_o[msb_i ? 3'h7 - n[2:0] : n[2:0]] <= sdo_i;
         n <= n + 4'h1;
      end else if (sck_i != s_q && n < 4'h8) begin
         b <= n[2:0];
      end
   end
endmodule : spi_slave_model
`default_nettype wire
